// [uepf_pkg.sv]
package uepf_pkg;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SUSP_TIME_US = 3000;
  localparam int SUSP_CYCLES = SUSP_TIME_US * CLK_MHZ;
  localparam int RSM_TIME_US = 1000;
  localparam int RSM_CYCLES = RSM_TIME_US * CLK_MHZ;

  // Bank geometry
  localparam logic [3:0] BANK_BYTES = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_ENAB = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_FNUMH = 8'h10;
  localparam logic [7:0] OFS_FNUML = 8'h14;
  localparam logic [7:0] OFS_EPCFG = 8'h18;
  localparam logic [7:0] OFS_OSTAT = 8'h20;
  localparam logic [7:0] OFS_OCNT = 8'h24;
  localparam logic [7:0] OFS_ODATA = 8'h28;
  localparam logic [7:0] OFS_OEN = 8'h2c;
  localparam logic [7:0] OFS_ISTAT = 8'h30;
  localparam logic [7:0] OFS_IDATA = 8'h34;
  localparam logic [7:0] OFS_IEN = 8'h38;

  // device_control fields
  localparam int CTRL_DETACH = 0;
  localparam int CTRL_RMW = 1;
  localparam int CTRL_LSM = 2;
  localparam logic DETACH_RESET = 1'b1;

  // device_interrupt_flags / enables fields
  localparam int FLG_UPRS = 6;
  localparam int FLG_EORS = 5;
  localparam int FLG_WAKE = 4;
  localparam int FLG_EORST = 3;
  localparam int FLG_SOF = 2;
  localparam int FLG_SUSP = 0;
  localparam logic [7:0] FLAGS_MASK = 8'h7d;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENAB_RESET = 8'h00;

  // device_address and frame_number_high fields
  localparam int ADDR_EN = 7;
  localparam int FN_CRCERR = 4;

  // Endpoint status fields
  localparam int EP_BANKCTL = 7;
  localparam int EP_ACCESS = 5;
  localparam int EP_UNDER = 3;
  localparam int EP_OVER = 2;
  localparam int EP_STALL = 1;
  localparam int EP_MAIN = 0;
  localparam logic [7:0] OUT_FLAG_MASK = 8'h0f;
  localparam logic [7:0] IN_FLAG_MASK = 8'h09;
  localparam logic [7:0] IN_FLAGS_RESET = 8'h01;

  // Endpoint configuration fields
  localparam int CFG_ODBL = 0;
  localparam int CFG_IDBL = 1;
  localparam int CFG_OISO = 2;
  localparam int CFG_IISO = 3;
  localparam int CFG_KILL = 4;
  localparam logic [3:0] EPCFG_RESET = 4'h0;

  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
    logic done;
    logic crc_err;
  } uepf_out_pkt_t;

  typedef struct packed {
    logic idle_j;
    logic activity;
    logic sof;
    logic sof_crc_err;
    logic [10:0] sof_frame;
    logic bus_reset_end;
    logic resume_end;
  } uepf_line_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } uepf_in_stream_t;

  typedef struct packed {
    logic out_ack;
    logic out_nak;
    logic in_nak;
  } uepf_hshake_t;

  // Sticky flag update: a hardware set wins over a clear
  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic [7:0] clr);
    flag_next = (cur & ~clr) | set;
  endfunction

endpackage

// [uepf_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Read-allowed set while unread bytes remain
// - Bank filled sets rx flag; irq if enabled
// - Byte count exposed; each read pops next byte
// - Release onto full second bank sets rx flag again
// - IN bank free sets tx flag and bank_control
// - Write-allowed set while IN bank has room
// - Release onto free next bank sets tx flag
// - Discard bit kills last written IN bank
// - Iso IN token on empty bank flags underflow
// - Iso OUT packet with banks full dropped, underflow
// - Iso OUT CRC error sets stall flag and rx
// - Oversized OUT packet: overflow, ack, keep head
// - Speed bit picks pull-up; ignored in host
// - Remote wake only in suspend; hardware clears
// - Detach removes pull-up, clearing reconnects it
// - Device flags set by hardware, software clears
// - Frame start flag per SOF, with CRC error
// - Address enable set by software, hardware clears
// - Frame number kept from last SOF
// - OUT bank full sets rx and bank_control
// - Clearing bank_control frees and switches bank
module uepf_top
  import uepf_pkg::*;
#(
  parameter int SUSPEND_CYCLES = SUSP_CYCLES,
  parameter int RESUME_CYCLES = RSM_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // USB line side
  input wire logic host_mode,
  input wire uepf_line_t line,
  input wire uepf_out_pkt_t out_pkt,
  input wire logic in_token,
  output uepf_in_stream_t in_strm,
  output uepf_hshake_t hshake,
  // Pads and status
  output logic dp_pullup,
  output logic dm_pullup,
  output logic resume_drive,
  output logic [6:0] usb_address,
  output logic ep_out_irq,
  output logic ep_in_irq,
  output logic device_irq
);

  logic rd_wait;
  logic wr_pend;
  logic [7:0] a_ofs;
  logic [7:0] wd;
  logic [7:0] rmux;
  logic acc;

  logic detach;
  logic low_speed_select;
  logic rmw;
  logic rmw_start;
  logic [23:0] rsm_cnt;
  logic [23:0] susp_cnt;
  logic susp_hit;
  logic [7:0] flags;
  logic [7:0] enab;
  logic [7:0] f_set;
  logic [7:0] f_clr;
  logic [6:0] addr_val;
  logic addr_en;
  logic [10:0] frame_counter_value;
  logic fn_crc;
  logic [3:0] cfg;
  logic kill;

  logic [7:0] omem [0:1][0:7];
  logic [1:0] obusy;
  logic [3:0] ocnt [0:1];
  logic ocur;
  logic ofill;
  logic [3:0] owp;
  logic [3:0] orp;
  logic orecv;
  logic [7:0] ofl;
  logic [7:0] oen;
  logic [7:0] oset;
  logic o_done_ok;
  logic o_rel;
  logic o_access;
  logic o_pop;

  logic [7:0] imem [0:1][0:7];
  logic [1:0] ibusy;
  logic [3:0] icnt [0:1];
  logic icur;
  logic isend;
  logic [3:0] iwp;
  logic [3:0] irp;
  logic isending;
  logic [7:0] ifl;
  logic [7:0] ien;
  logic [7:0] iset;
  logic i_access;
  logic i_push;
  logic i_rel;
  logic i_last;
  logic i_end;
  logic ilast;
  logic i_kill;

  // Bus slave: writes take effect at the end of their data phase,
  // reads insert one wait state so they see every earlier write.
  assign acc = hsel & htrans[1] & hready;
  assign wd = hwdata[7:0];
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_ofs <= 8'h00;
      rd_wait <= 1'b0;
      wr_pend <= 1'b0;
    end else begin
      rd_wait <= acc & ~hwrite;
      wr_pend <= acc & hwrite;
      if (acc) begin
        a_ofs <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
      hrdata <= {24'h00_0000, rmux};
    end
  end

  // Device control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detach <= DETACH_RESET;
      low_speed_select <= 1'b0;
    end else if (wr_pend && a_ofs == OFS_CTRL) begin
      detach <= wd[CTRL_DETACH];
      low_speed_select <= wd[CTRL_LSM];
    end
  end

  assign dp_pullup = ~detach & ~host_mode & ~low_speed_select;
  assign dm_pullup = ~detach & ~host_mode & low_speed_select;

  // Remote wake; a software clear is ignored
  assign rmw_start = wr_pend && a_ofs == OFS_CTRL && wd[CTRL_RMW] &&
                     flags[FLG_SUSP] && !rmw;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rmw <= 1'b0;
      rsm_cnt <= 24'h00_0000;
    end else if (rmw_start) begin
      rmw <= 1'b1;
      rsm_cnt <= 24'(RESUME_CYCLES - 1);
    end else if (rmw) begin
      if (rsm_cnt == 24'h00_0000) begin
        rmw <= 1'b0;
      end else begin
        rsm_cnt <= rsm_cnt - 24'h00_0001;
      end
    end
  end

  assign resume_drive = rmw;

  // Idle J counter for suspend detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_cnt <= 24'h00_0000;
    end else if (!line.idle_j) begin
      susp_cnt <= 24'h00_0000;
    end else if (susp_cnt != 24'(SUSPEND_CYCLES)) begin
      susp_cnt <= susp_cnt + 24'h00_0001;
    end
  end

  assign susp_hit = line.idle_j &&
                    susp_cnt == 24'(SUSPEND_CYCLES - 1);

  // Device interrupt flags
  always_comb begin
    f_set = 8'h00;
    f_set[FLG_UPRS] = rmw_start;
    f_set[FLG_EORS] = line.resume_end;
    f_set[FLG_WAKE] = line.activity;
    f_set[FLG_EORST] = line.bus_reset_end;
    f_set[FLG_SOF] = line.sof;
    f_set[FLG_SUSP] = susp_hit;
    f_clr = (wr_pend && a_ofs == OFS_FLAGS) ? ~wd : 8'h00;
    f_clr[FLG_SUSP] = f_clr[FLG_SUSP] | line.activity | rmw_start;
    f_clr[FLG_WAKE] = f_clr[FLG_WAKE] | susp_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= flag_next(flags, f_set, f_clr) & FLAGS_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enab <= ENAB_RESET;
    end else if (wr_pend && a_ofs == OFS_ENAB) begin
      enab <= wd & FLAGS_MASK;
    end
  end

  assign device_irq = |(flags & enab);

  // Device address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_val <= 7'h00;
      addr_en <= 1'b0;
    end else begin
      if (wr_pend && a_ofs == OFS_ADDR) begin
        addr_val <= wd[6:0];
      end
      if (line.bus_reset_end) begin
        addr_en <= 1'b0;
      end else if (wr_pend && a_ofs == OFS_ADDR && wd[ADDR_EN]) begin
        addr_en <= 1'b1;
      end
    end
  end

  assign usb_address = addr_en ? addr_val : 7'h00;

  // Frame number, updated even on a corrupted SOF
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_counter_value <= 11'h000;
      fn_crc <= 1'b0;
    end else if (line.sof) begin
      frame_counter_value <= line.sof_frame;
      fn_crc <= line.sof_crc_err;
    end
  end

  // Endpoint configuration; the discard bit self-clears
  assign kill = wr_pend && a_ofs == OFS_EPCFG && wd[CFG_KILL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= EPCFG_RESET;
      oen <= 8'h00;
      ien <= 8'h00;
    end else begin
      if (wr_pend && a_ofs == OFS_EPCFG) begin
        cfg <= wd[3:0];
      end
      if (wr_pend && a_ofs == OFS_OEN) begin
        oen <= wd & OUT_FLAG_MASK;
      end
      if (wr_pend && a_ofs == OFS_IEN) begin
        ien <= wd & IN_FLAG_MASK;
      end
    end
  end

  // OUT endpoint
  assign o_done_ok = out_pkt.done && orecv &&
                     !(out_pkt.crc_err && !cfg[CFG_OISO]);
  assign o_rel = wr_pend && a_ofs == OFS_OSTAT && !wd[EP_BANKCTL] &&
                 obusy[ocur];
  assign o_access = obusy[ocur] && orp < ocnt[ocur];
  assign o_pop = rd_wait && a_ofs == OFS_ODATA && o_access;

  always_comb begin
    oset = 8'h00;
    oset[EP_MAIN] = (o_done_ok && ofill == ocur && !o_rel) ||
                    (o_rel && cfg[CFG_ODBL] && (obusy[~ocur] ||
                     (o_done_ok && ofill == ~ocur)));
    oset[EP_STALL] = o_done_ok && cfg[CFG_OISO] &&
                     out_pkt.crc_err;
    oset[EP_OVER] = orecv && out_pkt.valid &&
                    owp == BANK_BYTES;
    oset[EP_UNDER] = out_pkt.start && obusy[ofill] &&
                     cfg[CFG_OISO];
  end

  always_ff @(posedge hclk) begin
    if (orecv && out_pkt.valid && owp < BANK_BYTES) begin
      omem[ofill][owp[2:0]] <= out_pkt.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orecv <= 1'b0;
      owp <= 4'h0;
      obusy <= 2'b00;
      ocnt[0] <= 4'h0;
      ocnt[1] <= 4'h0;
      ofill <= 1'b0;
      ocur <= 1'b0;
      orp <= 4'h0;
    end else begin
      if (out_pkt.start) begin
        orecv <= !obusy[ofill];
        owp <= 4'h0;
      end else if (out_pkt.done) begin
        orecv <= 1'b0;
      end else if (orecv && out_pkt.valid && owp < BANK_BYTES) begin
        owp <= owp + 4'h1;
      end
      if (o_done_ok) begin
        obusy[ofill] <= 1'b1;
        ocnt[ofill] <= owp;
        ofill <= cfg[CFG_ODBL] ? ~ofill : 1'b0;
      end
      if (o_rel) begin
        obusy[ocur] <= 1'b0;
        ocur <= cfg[CFG_ODBL] ? ~ocur : 1'b0;
        orp <= 4'h0;
      end else if (o_pop) begin
        orp <= orp + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ofl <= 8'h00;
    end else begin
      ofl <= flag_next(ofl, oset, (wr_pend && a_ofs == OFS_OSTAT) ?
                       ~wd : 8'h00) & OUT_FLAG_MASK;
    end
  end

  assign ep_out_irq = |(ofl & oen);

  // IN endpoint
  assign i_access = !ibusy[icur] && iwp < BANK_BYTES;
  assign i_push = wr_pend && a_ofs == OFS_IDATA && i_access;
  assign i_rel = wr_pend && a_ofs == OFS_ISTAT && !wd[EP_BANKCTL] &&
                 !ibusy[icur];
  assign i_last = 4'(irp + 4'h1) >= icnt[isend];
  assign i_end = isending && i_last;
  assign ilast = cfg[CFG_IDBL] ? ~icur : icur;
  assign i_kill = kill && ibusy[ilast] &&
                  !(isending && isend == ilast);

  always_comb begin
    iset = 8'h00;
    iset[EP_MAIN] = (i_end && isend == icur) ||
                    (i_kill && ilast == icur) ||
                    (i_rel && cfg[CFG_IDBL] && (!ibusy[~icur] ||
                     (i_end && isend == ~icur)));
    iset[EP_UNDER] = in_token && !isending && !ibusy[isend] &&
                     cfg[CFG_IISO];
  end

  always_ff @(posedge hclk) begin
    if (i_push) begin
      imem[icur][iwp[2:0]] <= wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ibusy <= 2'b00;
      icnt[0] <= 4'h0;
      icnt[1] <= 4'h0;
      icur <= 1'b0;
      isend <= 1'b0;
      iwp <= 4'h0;
      irp <= 4'h0;
      isending <= 1'b0;
    end else begin
      if (i_rel) begin
        ibusy[icur] <= 1'b1;
        icnt[icur] <= iwp;
        icur <= cfg[CFG_IDBL] ? ~icur : 1'b0;
        iwp <= 4'h0;
      end else if (i_push) begin
        iwp <= iwp + 4'h1;
      end
      if (i_kill) begin
        ibusy[ilast] <= 1'b0;
      end
      if (i_end) begin
        ibusy[isend] <= 1'b0;
        isend <= cfg[CFG_IDBL] ? ~isend : 1'b0;
        isending <= 1'b0;
      end else if (isending) begin
        irp <= irp + 4'h1;
      end else if (in_token && ibusy[isend]) begin
        isending <= 1'b1;
        irp <= 4'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ifl <= IN_FLAGS_RESET;
    end else begin
      ifl <= flag_next(ifl, iset, (wr_pend && a_ofs == OFS_ISTAT) ?
                       ~wd : 8'h00) & IN_FLAG_MASK;
    end
  end

  assign ep_in_irq = |(ifl & ien);

  // Line side outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_strm <= '0;
      hshake <= '0;
    end else begin
      in_strm.valid <= isending && irp < icnt[isend];
      in_strm.last <= i_end;
      in_strm.data <= imem[isend][irp[2:0]];
      hshake.out_ack <= o_done_ok && !cfg[CFG_OISO];
      hshake.out_nak <= out_pkt.done && !orecv && !cfg[CFG_OISO];
      hshake.in_nak <= in_token && !isending && !ibusy[isend];
    end
  end

  // Register read mux
  always_comb begin
    unique case (a_ofs)
      OFS_CTRL: rmux = {5'h00, low_speed_select, rmw, detach};
      OFS_FLAGS: rmux = flags;
      OFS_ENAB: rmux = enab;
      OFS_ADDR: rmux = {addr_en, addr_val};
      OFS_FNUMH: rmux = {3'h0, fn_crc, 1'b0, frame_counter_value[10:8]};
      OFS_FNUML: rmux = frame_counter_value[7:0];
      OFS_EPCFG: rmux = {4'h0, cfg};
      OFS_OSTAT: rmux = {obusy[ocur], 1'b0, o_access, 1'b0, ofl[3:0]};
      OFS_OCNT: rmux = {4'h0, obusy[ocur] ? ocnt[ocur] : 4'h0};
      OFS_ODATA: rmux = o_access ? omem[ocur][orp[2:0]] : 8'h00;
      OFS_OEN: rmux = oen;
      OFS_ISTAT: rmux = {!ibusy[icur], 1'b0, i_access, 1'b0, ifl[3:0]};
      OFS_IEN: rmux = ien;
      default: rmux = 8'h00;
    endcase
  end

endmodule

`default_nettype wire

// [uepf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uepf_host_model
  import uepf_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Towards the device
  output uepf_line_t line,
  output uepf_out_pkt_t out_pkt,
  output logic in_token
);
  initial begin
    line = '0;
    out_pkt = '0;
    in_token = 1'b0;
  end
  // OUT packet of n bytes counting up from b
  task automatic send_out(input int n, input logic [7:0] b, input logic e);
    @(posedge hclk);
    out_pkt.start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      out_pkt.start <= 1'b0;
      out_pkt.valid <= 1'b1;
      out_pkt.data <= b + 8'(i);
    end
    @(posedge hclk);
    out_pkt.start <= 1'b0;
    out_pkt.valid <= 1'b0;
    // Released data line must not keep its last value
    out_pkt.data <= ~out_pkt.data;
    out_pkt.done <= 1'b1;
    out_pkt.crc_err <= e;
    @(posedge hclk);
    out_pkt.done <= 1'b0;
    out_pkt.crc_err <= 1'b0;
  endtask
  task automatic token();
    @(posedge hclk);
    in_token <= 1'b1;
    @(posedge hclk);
    in_token <= 1'b0;
  endtask
  task automatic sof(input logic [10:0] f, input logic e);
    @(posedge hclk);
    line.sof <= 1'b1;
    line.sof_frame <= f;
    line.sof_crc_err <= e;
    @(posedge hclk);
    line.sof <= 1'b0;
    line.sof_crc_err <= 1'b0;
  endtask
  task automatic reset_end();
    @(posedge hclk);
    line.bus_reset_end <= 1'b1;
    @(posedge hclk);
    line.bus_reset_end <= 1'b0;
  endtask
  task automatic act();
    @(posedge hclk);
    line.activity <= 1'b1;
    line.resume_end <= 1'b1;
    @(posedge hclk);
    line.activity <= 1'b0;
    line.resume_end <= 1'b0;
  endtask
  task automatic set_idle(input logic v);
    @(posedge hclk);
    line.idle_j <= v;
  endtask
endmodule
`default_nettype wire

// [uepf_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module uepf_top_asserts
  import uepf_pkg::*;
#(
  parameter int RESUME_CYCLES = RSM_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Line side
  input wire logic host_mode,
  input wire uepf_line_t line,
  input wire uepf_out_pkt_t out_pkt,
  input wire logic in_token,
  input wire uepf_in_stream_t in_strm,
  input wire uepf_hshake_t hshake,
  // Pads
  input wire logic dp_pullup,
  input wire logic dm_pullup,
  input wire logic resume_drive,
  input wire logic [6:0] usb_address
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic wr_dp;
  int rsm_cnt;
  // Marks the data phase of a register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
    end else begin
      wr_dp <= hsel && htrans[1] && hready && hwrite;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsm_cnt <= 0;
    end else begin
      rsm_cnt <= resume_drive ? rsm_cnt + 1 : 0;
    end
  end
  sequence rd_addr;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (rd_addr |=> rd_wait)
    else $error("read wait state wrong");
  pull_excl_a: assert property (!(dp_pullup && dm_pullup))
    else $error("both pull-ups on");
  host_pull_a: assert property (host_mode |-> !dp_pullup && !dm_pullup)
    else $error("pull-up on in host mode");
  pull_cause_a: assert property ($changed(dp_pullup) |->
      $past(wr_dp) || $changed(host_mode))
    else $error("pull-up moved without cause");
  addr_cause_a: assert property ($changed(usb_address) |->
      $past(wr_dp) || $past(line.bus_reset_end))
    else $error("address moved without cause");
  ack_cause_a: assert property (hshake.out_ack || hshake.out_nak |->
      $past(out_pkt.done))
    else $error("handshake without packet end");
  nak_in_a: assert property (hshake.in_nak |-> $past(in_token))
    else $error("in nak without token");
  in_first_a: assert property ($rose(in_strm.valid) |->
      $past(in_token, 2))
    else $error("in data not two cycles after token");
  in_end_a: assert property (in_strm.last |=> !in_strm.valid)
    else $error("in data after last");
  resume_len_a: assert property (rsm_cnt <= RESUME_CYCLES + 2)
    else $error("upstream resume too long");
endmodule
bind uepf_top uepf_top_asserts #(.RESUME_CYCLES(RESUME_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .host_mode(host_mode), .line(line), .out_pkt(out_pkt),
  .in_token(in_token), .in_strm(in_strm), .hshake(hshake),
  .dp_pullup(dp_pullup), .dm_pullup(dm_pullup),
  .resume_drive(resume_drive), .usb_address(usb_address)
);
`default_nettype wire

// [usb_device_endpoint_fifo_irq_test.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_device_endpoint_fifo_irq_test
  import uepf_pkg::*;
;
  localparam int SUSP_N = 20;
  localparam int RSM_N = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic host_mode = 1'b0;
  logic hreadyout, hresp, dp_pullup, dm_pullup, resume_drive, in_token;
  logic ep_out_irq, ep_in_irq, device_irq;
  logic [31:0] hrdata;
  logic [6:0] usb_address;
  uepf_line_t line;
  uepf_out_pkt_t out_pkt;
  uepf_in_stream_t in_strm;
  uepf_hshake_t hshake;
  int fails = 0;
  int checked = 0;
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  uepf_top #(.SUSPEND_CYCLES(SUSP_N), .RESUME_CYCLES(RSM_N)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .host_mode(host_mode), .line(line),
    .out_pkt(out_pkt), .in_token(in_token), .in_strm(in_strm),
    .hshake(hshake), .dp_pullup(dp_pullup), .dm_pullup(dm_pullup),
    .resume_drive(resume_drive), .usb_address(usb_address),
    .ep_out_irq(ep_out_irq), .ep_in_irq(ep_in_irq),
    .device_irq(device_irq)
  );
  uepf_host_model host (
    .hclk(hclk), .line(line), .out_pkt(out_pkt), .in_token(in_token)
  );
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic look();
    @(negedge hclk);
  endtask
  function automatic logic [31:0] pulls();
    pulls = 32'({dp_pullup, dm_pullup});
  endfunction
  // Settled values before an edge are what the edge samples
  task automatic wait_rdy(output logic [31:0] q);
    for (int i = 0; i < 20; i++) begin
      @(negedge hclk);
      q = hrdata;
      if (hreadyout === 1'b1) begin
        @(posedge hclk);
        return;
      end
    end
    fails++;
    wrap_up();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy(r);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy(r);
    q = r[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), 32'(q), 32'(e));
  endtask
  task automatic t_reset();
    rc(OFS_CTRL, 8'h01);
    rc(OFS_FLAGS, 8'h00);
    rc(OFS_ENAB, 8'h00);
    rc(OFS_ADDR, 8'h00);
    rc(OFS_ISTAT, 8'ha1);
    rc(OFS_OSTAT, 8'h00);
    wr(8'h40, 8'hff);
    rc(8'h40, 8'h00);
    look();
    chk("pulls", pulls(), 32'h0);
  endtask
  task automatic t_pads();
    wr(OFS_CTRL, 8'h00);
    look();
    chk("pulls", pulls(), 32'h2);
    wr(OFS_CTRL, 8'h04);
    look();
    chk("pulls", pulls(), 32'h1);
    @(posedge hclk);
    host_mode <= 1'b1;
    look();
    chk("pulls", pulls(), 32'h0);
    @(posedge hclk);
    host_mode <= 1'b0;
    wr(OFS_CTRL, 8'h01);
    look();
    chk("pulls", pulls(), 32'h0);
  endtask
  task automatic t_addr();
    wr(OFS_ADDR, 8'h85);
    look();
    chk("addr", 32'(usb_address), 32'h5);
    wr(OFS_ADDR, 8'h05);
    look();
    chk("addr", 32'(usb_address), 32'h5);
    host.reset_end();
    look();
    chk("addr", 32'(usb_address), 32'h0);
    rc(OFS_FLAGS, 8'h08);
    wr(OFS_FLAGS, 8'hff);
    rc(OFS_FLAGS, 8'h08);
    wr(OFS_ENAB, 8'h08);
    look();
    chk("dev_irq", 32'(device_irq), 32'h1);
    wr(OFS_FLAGS, 8'h00);
    look();
    chk("dev_irq", 32'(device_irq), 32'h0);
    wr(OFS_ENAB, 8'h00);
  endtask
  task automatic t_sof();
    host.sof(11'h5a3, 1'b1);
    rc(OFS_FNUMH, 8'h15);
    rc(OFS_FNUML, 8'ha3);
    rc(OFS_FLAGS, 8'h04);
    host.act();
    rc(OFS_FLAGS, 8'h34);
    wr(OFS_FLAGS, 8'h00);
  endtask
  task automatic t_susp();
    wr(OFS_CTRL, 8'h02);
    look();
    chk("resume", 32'(resume_drive), 32'h0);
    host.set_idle(1'b1);
    repeat (SUSP_N - 8) @(posedge hclk);
    rc(OFS_FLAGS, 8'h00);
    repeat (8) @(posedge hclk);
    host.set_idle(1'b0);
    rc(OFS_FLAGS, 8'h01);
    wr(OFS_CTRL, 8'h02);
    look();
    chk("resume", 32'(resume_drive), 32'h1);
    rc(OFS_FLAGS, 8'h40);
    wr(OFS_CTRL, 8'h00);
    look();
    chk("resume", 32'(resume_drive), 32'h1);
    repeat (RSM_N) @(posedge hclk);
    rc(OFS_CTRL, 8'h00);
    wr(OFS_FLAGS, 8'h00);
  endtask
  task automatic t_out();
    wr(OFS_OEN, 8'h01);
    host.send_out(3, 8'h10, 1'b0);
    look();
    chk("hshake", 32'(hshake), 32'h4);
    chk("out_irq", 32'(ep_out_irq), 32'h1);
    rc(OFS_OSTAT, 8'ha1);
    rc(OFS_OCNT, 8'h03);
    for (int i = 0; i < 3; i++) rc(OFS_ODATA, 8'(8'h10 + i));
    rc(OFS_OSTAT, 8'h81);
    wr(OFS_OSTAT, 8'h80);
    look();
    chk("out_irq", 32'(ep_out_irq), 32'h0);
    rc(OFS_OSTAT, 8'h80);
    wr(OFS_OSTAT, 8'h00);
    rc(OFS_OSTAT, 8'h00);
  endtask
  task automatic t_over();
    host.send_out(10, 8'h20, 1'b0);
    look();
    chk("hshake", 32'(hshake), 32'h4);
    rc(OFS_OSTAT, 8'ha5);
    rc(OFS_OCNT, 8'h08);
    for (int i = 0; i < 8; i++) rc(OFS_ODATA, 8'(8'h20 + i));
    wr(OFS_OSTAT, 8'h00);
  endtask
  task automatic t_dbl();
    wr(OFS_EPCFG, 8'h01);
    host.send_out(1, 8'h30, 1'b0);
    host.send_out(2, 8'h40, 1'b0);
    host.send_out(1, 8'h50, 1'b0);
    look();
    chk("hshake", 32'(hshake), 32'h2);
    wr(OFS_OSTAT, 8'h80);
    wr(OFS_OSTAT, 8'h00);
    rc(OFS_OSTAT, 8'ha1);
    rc(OFS_OCNT, 8'h02);
    rc(OFS_ODATA, 8'h40);
    host.send_out(1, 8'h60, 1'b0);
    wr(OFS_EPCFG, 8'h05);
    host.send_out(1, 8'h70, 1'b0);
    rc(OFS_OSTAT, 8'ha9);
    wr(OFS_OSTAT, 8'h00);
    wr(OFS_OSTAT, 8'h00);
    host.send_out(2, 8'h70, 1'b1);
    rc(OFS_OSTAT, 8'ha3);
    wr(OFS_OSTAT, 8'h00);
    wr(OFS_EPCFG, 8'h00);
  endtask
  task automatic t_in();
    wr(OFS_IEN, 8'h01);
    look();
    chk("in_irq", 32'(ep_in_irq), 32'h1);
    wr(OFS_ISTAT, 8'h80);
    rc(OFS_ISTAT, 8'ha0);
    for (int i = 0; i < 8; i++) wr(OFS_IDATA, 8'(8'h80 + i));
    rc(OFS_ISTAT, 8'h80);
    wr(OFS_ISTAT, 8'h00);
    rc(OFS_ISTAT, 8'h00);
    host.token();
    look();
    for (int i = 0; i < 6 && in_strm.valid !== 1'b1; i++) look();
    for (int i = 0; i < 8; i++) begin
      chk("in_strm", 32'(in_strm), {22'h0, 1'b1, i == 7, 8'(8'h80 + i)});
      look();
    end
    rc(OFS_ISTAT, 8'ha1);
    wr(OFS_EPCFG, 8'h08);
    host.token();
    look();
    chk("hshake", 32'(hshake), 32'h1);
    rc(OFS_ISTAT, 8'ha9);
    wr(OFS_IDATA, 8'h11);
    wr(OFS_ISTAT, 8'h00);
    rc(OFS_ISTAT, 8'h00);
    wr(OFS_EPCFG, 8'h18);
    rc(OFS_EPCFG, 8'h08);
    rc(OFS_ISTAT, 8'ha1);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_pads();
    t_addr();
    t_sof();
    t_susp();
    t_out();
    t_over();
    t_dbl();
    t_in();
    wrap_up();
  end
endmodule
`default_nettype wire
